// *** dv/cmd_status_unit_tb.sv ***
// self-checking bench for the flash command and status unit
`default_nettype none
`include "flash_consts.svh"

module cmd_status_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // pins driven by the bench
  logic        clk = 1'b0, rst_n = 1'b0, pd_n = 1'b0;
  logic        oe_n = 1'b1, we_n = 1'b1, adv_n = 1'b1;
  logic        wsel_n = 1'b1, wp_n = 1'b1, s5 = 1'b0, s12 = 1'b1;
  logic [1:0]  cs_n = 2'h0;
  logic [20:0] addr = 21'h0;
  logic [15:0] dq = 16'h0;
  // pins seen by the bench
  logic [15:0] dq_out, arr_data;
  logic [20:0] arr_addr;
  logic [2:0]  lat;
  logic [1:0]  dq_oe_n;
  logic        rb_out, rb_oe_n, rb_wire, bank_odd;
  int          mismatches = 0;
  int          checked = 0;

  // short op time keeps suspend reachable within a few writes
  cmd_status_unit #(.OP_CYCLES(20)) u_cmd_status_unit (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .POWER_DOWN_N_IN(pd_n),
    .CHIP_SELECT_PAIR_N_IN(cs_n), .OUTPUT_ENABLE_N_IN(oe_n),
    .WRITE_ENABLE_N_IN(we_n), .ADDRESS_VALID_N_IN(adv_n),
    .WIDTH_SELECT_N_IN(wsel_n), .WRITE_PROTECT_N_IN(wp_n),
    .PROG_SUPPLY_5V_IN(s5), .PROG_SUPPLY_12V_IN(s12),
    .ADDR_IN(addr), .DQ_IN(dq), .DQ_OUT(dq_out), .DQ_OE_N_OUT(dq_oe_n),
    .READY_BUSY_N_IN(rb_wire), .READY_BUSY_N_OUT(rb_out),
    .READY_BUSY_N_OE_N_OUT(rb_oe_n), .ARRAY_ADDR_OUT(arr_addr),
    .ARRAY_BANK_ODD_OUT(bank_odd), .ARRAY_DATA_IN(arr_data),
    .NV_LOCK_IN(16'hFFFE), .READ_LATENCY_CONFIG_OUT(lat));

  flash_array_model u_flash_array_model (
    .addr_in(arr_addr), .data_out(arr_data), .rb_oe_n_in(rb_oe_n),
    .rb_in(rb_out), .rb_wire_out(rb_wire));

  always #25 clk = ~clk;

  // advance n edges, then move off the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // write cycle; held past the synchroniser before release
  task automatic wr(input logic [7:0] code, input logic [20:0] a);
    oe_n = 1'b1;
    addr = a;
    dq = {8'hA5, code};
    we_n = 1'b0;
    step(3);
    we_n = 1'b1;
    step(4);
  endtask

  // read with output enabled; strobe low only when latching
  task automatic rd(input logic [20:0] a, input logic [15:0] exp,
                    input logic lt);
    addr = a;
    adv_n = ~lt;
    oe_n = 1'b0;
    step(5);
    check(dq_out, exp);
    adv_n = 1'b1;
    step(1);
  endtask

  // error bits are only trusted once the pin shows ready
  task automatic wait_ready();
    int i;
    for (i = 0; i < 200 && rb_wire !== 1'b1; i++) step(1);
    if (rb_wire !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask

  // main sequence
  initial begin
    step(12);
    rst_n = 1'b1;
    pd_n = 1'b1;
    step(3);
    check(16'(lat), 16'h0004);
    rd(21'h000102, 16'h02FD, 1'b1);
    check(16'(bank_odd), 16'h0001);
    check(16'(dq_oe_n), 16'h0000);
    rd(21'h000200, 16'h02FD, 1'b0);
    rd(21'h000200, 16'h00FF, 1'b1);
    check(16'(bank_odd), 16'h0000);
    cs_n = 2'h1;
    step(3);
    check(16'(dq_oe_n), 16'h0003);
    cs_n = 2'h0;
    // identifier codes in byte mode
    wsel_n = 1'b0;
    wr(`CMD_IDENT, 21'h0);
    rd(21'h000000, 16'h005A, 1'b1);
    rd(21'h000001, 16'h00C3, 1'b1);
    check(16'(dq_oe_n), 16'h0002);
    wr(`CMD_READ_ARRAY, 21'h0);
    rd(21'h000305, 16'h0005, 1'b1);
    wsel_n = 1'b1;
    // locks read locked until the upload
    wr(`CMD_READ_EXT, 21'h0);
    rd(21'h020004, 16'h0080, 1'b1);
    rd(21'h000008, 16'h0080, 1'b1);
    wr(`CMD_UPLOAD, 21'h0);
    wr(`CMD_CONFIRM, 21'h0);
    wait_ready();
    wr(`CMD_READ_EXT, 21'h0);
    rd(21'h000004, 16'h00C0, 1'b1);
    rd(21'h020004, 16'h0080, 1'b1);
    wr(`CMD_CONFIG, 21'h0);
    wr(8'h10, 21'h0);
    check(16'(lat), 16'h0002);
    // good program, busy then ready
    wr(`CMD_PROG, 21'h0);
    wr(8'h3C, 21'h000010);
    check(16'(rb_wire), 16'h0000);
    rd(21'h0, 16'h0000, 1'b1);
    wait_ready();
    rd(21'h0, 16'h0080, 1'b1);
    // supply missing only while the op is entered
    s12 = 1'b0;
    wr(`CMD_PROG_ALT, 21'h0);
    wr(8'h00, 21'h000010);
    s12 = 1'b1;
    wait_ready();
    rd(21'h0, 16'h0088, 1'b1);
    wr(`CMD_READ_EXT, 21'h0);
    rd(21'h000008, 16'h00A0, 1'b1);
    rd(21'h000004, 16'h00E4, 1'b1);
    wr(`CMD_CLEAR, 21'h0);
    wr(`CMD_READ_COMPAT, 21'h0);
    rd(21'h0, 16'h0080, 1'b1);
    wr(`CMD_READ_EXT, 21'h0);
    rd(21'h000004, 16'h00C0, 1'b1);
    // erase with a wrong confirm byte
    wr(`CMD_ERASE, 21'h0);
    wr(8'h00, 21'h0);
    rd(21'h0, 16'h00B0, 1'b1);
    wr(`CMD_CLEAR, 21'h0);
    // erase, suspend, resume
    wr(`CMD_ERASE, 21'h0);
    wr(`CMD_CONFIRM, 21'h0);
    wr(`CMD_SUSPEND, 21'h0);
    check(16'(rb_wire), 16'h0001);
    rd(21'h0, 16'h00C0, 1'b1);
    wr(`CMD_CONFIRM, 21'h0);
    check(16'(rb_wire), 16'h0000);
    wait_ready();
    rd(21'h0, 16'h0080, 1'b1);
    // lock block 0, then program it with protection on
    s5 = 1'b1;
    s12 = 1'b0;
    wr(`CMD_LOCK, 21'h0);
    wr(`CMD_CONFIRM, 21'h0);
    wait_ready();
    wr(`CMD_READ_EXT, 21'h0);
    rd(21'h000004, 16'h0082, 1'b1);
    wp_n = 1'b0;
    wr(`CMD_PROG, 21'h0);
    wr(8'h11, 21'h000010);
    rd(21'h0, 16'h0090, 1'b1);
    // power-down in mid-program
    wr(`CMD_CLEAR, 21'h0);
    wp_n = 1'b1;
    wr(`CMD_PROG, 21'h0);
    wr(8'h22, 21'h100010);
    pd_n = 1'b0;
    oe_n = 1'b0;
    step(3);
    check(16'(rb_wire), 16'h0001);
    check(16'(dq_oe_n), 16'h0003);
    check(16'(lat), 16'h0004);
    pd_n = 1'b1;
    step(3);
    wr(`CMD_READ_EXT, 21'h0);
    rd(21'h000008, 16'h0080, 1'b1);
    stop_test();
  end
endmodule

`default_nettype wire

// *** dv/flash_array_model.sv ***
// array contents and ready/busy pull-up beside the flash unit
`default_nettype none

module flash_array_model (
  // array side
  input  wire logic [20:0] addr_in,
  output logic      [15:0] data_out,
  // open-drain ready/busy pin
  input  wire logic        rb_oe_n_in,
  input  wire logic        rb_in,
  output logic             rb_wire_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // pattern tied to the address, so a stale latch shows up
  assign data_out = {addr_in[7:0], ~addr_in[7:0]};
  // resistor pull-up holds the pin high once it is released
  assign rb_wire_out = rb_oe_n_in ? 1'b1 : rb_in;
endmodule

`default_nettype wire

// *** hdl/cmd_status_unit.sv ***
// bus decode, command interpreter and status registers of the flash
//
// What this block does
// - address latched on clock edge while strobe low
// - bank bit low even, high odd
// - selected only when both selects low
// - drive data on output enable, else float
// - power-down floats pins, releases ready/busy
// - identifier address picks maker or device code
// - ready/busy pulled low while machine runs
// - operations need a valid programming supply
// - compatible command codes decoded as listed
// - identifier command then maker, device reads
// - program, erase, suspend switch reads to status
// - clear command resets all error flags
// - extended read and lock block commands
// - lock bits read locked until upload
// - configuration command sets read latency
// - only low data byte decoded
// - compatible status bit layout
// - both errors flag improper command sequence
// - supply sampled only when operation starts
// - global status bit layout
// - block status bit layout
// - write protect low guards locked blocks
// - byte mode uses low lane only
// - read latency defaults to setting four
`default_nettype none
`include "flash_consts.svh"

module cmd_status_unit #(
  parameter int unsigned OP_CYCLES   = `OP_CYCLES,
  parameter logic [7:0]  MAKER_CODE  = 8'h5A, // arbitrary value
  parameter logic [7:0]  DEVICE_CODE = 8'hC3  // arbitrary value
) (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // bus control pins
  input  wire logic        POWER_DOWN_N_IN,
  input  wire logic [1:0]  CHIP_SELECT_PAIR_N_IN,
  input  wire logic        OUTPUT_ENABLE_N_IN,
  input  wire logic        WRITE_ENABLE_N_IN,
  input  wire logic        ADDRESS_VALID_N_IN,
  input  wire logic        WIDTH_SELECT_N_IN,
  input  wire logic        WRITE_PROTECT_N_IN,
  // programming supply detectors
  input  wire logic        PROG_SUPPLY_5V_IN,
  input  wire logic        PROG_SUPPLY_12V_IN,
  // address and data pins
  input  wire logic [20:0] ADDR_IN,
  input  wire logic [15:0] DQ_IN,
  output logic      [15:0] DQ_OUT,
  output logic      [1:0]  DQ_OE_N_OUT,
  // open-drain ready/busy pin
  input  wire logic        READY_BUSY_N_IN,
  output logic             READY_BUSY_N_OUT,
  output logic             READY_BUSY_N_OE_N_OUT,
  // array side
  output logic      [20:0] ARRAY_ADDR_OUT,
  output logic             ARRAY_BANK_ODD_OUT,
  input  wire logic [15:0] ARRAY_DATA_IN,
  input  wire logic [15:0] NV_LOCK_IN,
  output logic      [2:0]  READ_LATENCY_CONFIG_OUT
);

  localparam int unsigned PW = $bits(flash_pkg::bus_pins_t);
  localparam int unsigned NB = `NUM_BLOCKS;

  flash_pkg::bus_pins_t    pins_raw;
  flash_pkg::bus_pins_t    pins;
  logic [20:0]             addr_s;
  logic [15:0]             dq_s;
  logic                    sel;
  logic                    pd;
  logic                    wr_stb;
  logic [7:0]              cmd;
  logic [3:0]              blk_w;
  logic                    supply_ok;
  logic                    prot;
  logic [NB-1:0]           bset;
  logic [20:0]             la_q, la_d;
  logic                    we_prev_q, we_prev_d;
  logic [15:0]             dq_q, dq_d;
  logic [15:0]             word;
  flash_pkg::cmd_state_t   cst_q, cst_d;
  flash_pkg::read_mode_t   rmode_q, rmode_d;
  logic [2:0]              cfg_q, cfg_d;
  logic                    start, clr, improper;
  logic                    susp_req, resume_req;
  flash_pkg::op_t          start_op;
  flash_pkg::mach_state_t  mach_q, mach_d;
  flash_pkg::op_t          op_q, op_d;
  logic [3:0]              blk_q, blk_d;
  logic                    lvl_q, lvl_d;
  logic [NB-1:0]           lock_q, lock_d;
  logic                    go, op_done;
  logic                    set_supply, set_prog, set_erase, set_fail;
  flash_pkg::err_flags_t   err_q, err_d;
  logic                    gfail_q, gfail_d;
  logic [NB-1:0]           bfail_q, bfail_d;
  logic [NB-1:0]           bsup_q, bsup_d;
  flash_pkg::compat_t      compat_st;
  flash_pkg::global_t      glob_st;
  flash_pkg::block_t       bst [NB];

  // every pin crosses two flops before use
  assign pins_raw = '{pd_n: POWER_DOWN_N_IN,
                      cs_n: CHIP_SELECT_PAIR_N_IN,
                      oe_n: OUTPUT_ENABLE_N_IN,
                      we_n: WRITE_ENABLE_N_IN,
                      addr_valid_n: ADDRESS_VALID_N_IN,
                      byte_n: WIDTH_SELECT_N_IN,
                      wp_n: WRITE_PROTECT_N_IN,
                      supply_5v: PROG_SUPPLY_5V_IN,
                      supply_12v: PROG_SUPPLY_12V_IN};

  pin_sync #(
    .W (PW + 37)
  ) u_sync (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .d_in       ({pins_raw, ADDR_IN, DQ_IN}),
    .q_out      ({pins, addr_s, dq_s})
  );

  // decoded bus conditions
  assign sel       = !pins.cs_n[0] && !pins.cs_n[1];
  assign pd        = pins.pd_n;
  assign wr_stb    = pd && sel && pins.we_n && !we_prev_q;
  assign cmd       = dq_s[7:0];
  assign blk_w     = addr_s[`BLK_MSB:`BLK_LSB];
  assign supply_ok = pins.supply_5v || pins.supply_12v;
  assign bset      = NB'(1) << blk_w;

  // address latch and registered read data
  always_comb begin
    la_d      = la_q;
    // held high in power-down, so waking gives no false write edge
    we_prev_d = pins.we_n || !pd;
    if (pd && sel && pins.we_n && !pins.addr_valid_n) begin
      la_d = addr_s;
    end
  end

  // read word by mode; held until a command or power-down changes it
  always_comb begin
    word = 16'h0000;
    case (rmode_q)
      flash_pkg::RD_ARRAY: word = ARRAY_DATA_IN;
      flash_pkg::RD_IDENT: begin
        if (pins.byte_n ? la_q[20:2] == '0 : la_q[20:1] == '0) begin
          word = {8'h00, (pins.byte_n ? la_q[1] : la_q[0]) ?
                  DEVICE_CODE : MAKER_CODE};
        end
      end
      flash_pkg::RD_COMPAT: word = {8'h00, compat_st};
      flash_pkg::RD_EXT: begin
        if (la_q[16:1] == `EXT_GLB_OFS >> 1) begin
          word = {8'h00, glob_st};
        end else if (la_q[16:1] == `EXT_BLK_OFS >> 1) begin
          word = {8'h00, bst[la_q[`BLK_MSB:`BLK_LSB]]};
        end
      end
      default: word = 16'h0000;
    endcase
    dq_d = word;
    if (!pins.byte_n) begin
      dq_d = {8'h00, (la_q[0] && rmode_q == flash_pkg::RD_ARRAY) ?
              word[15:8] : word[7:0]};
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      la_q      <= '0;
      we_prev_q <= 1'b1;
      dq_q      <= 16'h0000;
    end else begin
      la_q      <= la_d;
      we_prev_q <= we_prev_d;
      dq_q      <= dq_d;
    end
  end

  // command interpreter
  always_comb begin
    cst_d      = cst_q;
    rmode_d    = rmode_q;
    cfg_d      = cfg_q;
    start      = 1'b0;
    start_op   = flash_pkg::OP_PROG;
    clr        = 1'b0;
    improper   = 1'b0;
    susp_req   = 1'b0;
    resume_req = 1'b0;
    if (wr_stb) begin
      case (cst_q)
        flash_pkg::C_IDLE: begin
          case (cmd)
            `CMD_READ_ARRAY:  rmode_d = flash_pkg::RD_ARRAY;
            `CMD_IDENT:       rmode_d = flash_pkg::RD_IDENT;
            `CMD_READ_COMPAT: rmode_d = flash_pkg::RD_COMPAT;
            `CMD_READ_EXT:    rmode_d = flash_pkg::RD_EXT;
            `CMD_CLEAR:       clr = 1'b1;
            `CMD_PROG, `CMD_PROG_ALT: begin
              cst_d   = flash_pkg::C_PROG;
              rmode_d = flash_pkg::RD_COMPAT;
            end
            `CMD_ERASE: begin
              cst_d   = flash_pkg::C_ERASE;
              rmode_d = flash_pkg::RD_COMPAT;
            end
            `CMD_SUSPEND: begin
              susp_req = 1'b1;
              rmode_d  = flash_pkg::RD_COMPAT;
            end
            `CMD_CONFIRM: resume_req = 1'b1;
            `CMD_LOCK:    cst_d = flash_pkg::C_LOCK;
            `CMD_UPLOAD:  cst_d = flash_pkg::C_UPLOAD;
            `CMD_CONFIG:  cst_d = flash_pkg::C_CONFIG;
            default:      cst_d = flash_pkg::C_IDLE;
          endcase
        end
        flash_pkg::C_PROG: begin
          cst_d = flash_pkg::C_IDLE;
          start = 1'b1;
        end
        flash_pkg::C_CONFIG: begin
          cst_d = flash_pkg::C_IDLE;
          cfg_d = dq_s[`LAT_MSB:`LAT_LSB];
        end
        default: begin
          cst_d = flash_pkg::C_IDLE;
          if (cmd == `CMD_CONFIRM) begin
            start    = 1'b1;
            start_op = (cst_q == flash_pkg::C_ERASE) ? flash_pkg::OP_ERASE :
                       (cst_q == flash_pkg::C_LOCK) ? flash_pkg::OP_LOCK :
                       flash_pkg::OP_UPLOAD;
          end else begin
            improper = 1'b1;
          end
        end
      endcase
    end
    if (!pd) begin
      cst_d   = flash_pkg::C_IDLE;
      rmode_d = flash_pkg::RD_ARRAY;
      cfg_d   = `LAT_DEFAULT;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cst_q   <= flash_pkg::C_IDLE;
      rmode_q <= flash_pkg::RD_ARRAY;
      cfg_q   <= `LAT_DEFAULT;
    end else begin
      cst_q   <= cst_d;
      rmode_q <= rmode_d;
      cfg_q   <= cfg_d;
    end
  end

  // locked block, write protect low: no program or erase
  assign prot = lock_q[blk_w] && !pins.wp_n &&
                (start_op == flash_pkg::OP_PROG ||
                 start_op == flash_pkg::OP_ERASE);

  op_timer #(
    .CYCLES (OP_CYCLES)
  ) u_timer (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .clear_in   (!pd),
    .start_in   (go),
    .hold_in    (mach_q == flash_pkg::M_SUSP),
    .done_out   (op_done)
  );

  // write state machine; a start while busy is dropped
  always_comb begin
    mach_d     = mach_q;
    op_d       = op_q;
    blk_d      = blk_q;
    lvl_d      = lvl_q;
    lock_d     = lock_q;
    go         = 1'b0;
    set_supply = 1'b0;
    set_prog   = improper;
    set_erase  = improper;
    set_fail   = 1'b0;
    case (mach_q)
      flash_pkg::M_IDLE: begin
        if (start) begin
          op_d  = start_op;
          blk_d = blk_w;
          lvl_d = pins.supply_5v;
          if (!supply_ok) begin
            set_supply = 1'b1;
            set_fail   = 1'b1;
          end else if (prot) begin
            set_prog  = start_op == flash_pkg::OP_PROG;
            set_erase = start_op == flash_pkg::OP_ERASE;
            set_fail  = 1'b1;
          end else begin
            mach_d = flash_pkg::M_BUSY;
            go     = 1'b1;
          end
        end
      end
      flash_pkg::M_BUSY: begin
        if (op_done) begin
          mach_d = flash_pkg::M_IDLE;
          if (op_q == flash_pkg::OP_LOCK) begin
            lock_d[blk_q] = 1'b1;
          end else if (op_q == flash_pkg::OP_UPLOAD) begin
            lock_d = NV_LOCK_IN;
          end
        end else if (susp_req && op_q == flash_pkg::OP_ERASE) begin
          mach_d = flash_pkg::M_SUSP;
        end
      end
      flash_pkg::M_SUSP: begin
        if (resume_req) begin
          mach_d = flash_pkg::M_BUSY;
        end
      end
      default: mach_d = flash_pkg::M_IDLE;
    endcase
    if (!pd) begin
      mach_d = flash_pkg::M_IDLE;
      lock_d = '1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mach_q <= flash_pkg::M_IDLE;
      op_q   <= flash_pkg::OP_PROG;
      blk_q  <= 4'h0;
      lvl_q  <= 1'b0;
      lock_q <= '1;
    end else begin
      mach_q <= mach_d;
      op_q   <= op_d;
      blk_q  <= blk_d;
      lvl_q  <= lvl_d;
      lock_q <= lock_d;
    end
  end

  // sticky error flags; a set in the clear cycle wins
  always_comb begin
    err_d.supply = (err_q.supply && !clr) || set_supply;
    err_d.prog   = (err_q.prog && !clr) || set_prog;
    err_d.erase  = (err_q.erase && !clr) || set_erase;
    gfail_d      = (gfail_q && !clr) || set_fail;
    bfail_d      = (bfail_q & ~{NB{clr}}) | (set_fail ? bset : '0);
    bsup_d       = (bsup_q & ~{NB{clr}}) | (set_supply ? bset : '0);
    if (!pd) begin
      err_d   = '0;
      gfail_d = 1'b0;
      bfail_d = '0;
      bsup_d  = '0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      err_q   <= '0;
      gfail_q <= 1'b0;
      bfail_q <= '0;
      bsup_q  <= '0;
    end else begin
      err_q   <= err_d;
      gfail_q <= gfail_d;
      bfail_q <= bfail_d;
      bsup_q  <= bsup_d;
    end
  end

  // status register images
  assign compat_st = '{machine_ready: mach_q != flash_pkg::M_BUSY,
                       erase_suspended: mach_q == flash_pkg::M_SUSP,
                       erase_failed: err_q.erase,
                       program_failed: err_q.prog,
                       prog_supply_error: err_q.supply,
                       rsv: 3'h0};
  assign glob_st = '{machine_ready: mach_q != flash_pkg::M_BUSY,
                     op_suspended: mach_q == flash_pkg::M_SUSP,
                     device_op_failed: gfail_q,
                     rsv: 5'h00};

  for (genvar b = 0; b < NB; b++) begin : g_blk
    assign bst[b] = '{block_ready: !(mach_q == flash_pkg::M_BUSY &&
                                     blk_q == 4'(b)),
                      block_unlocked: !lock_q[b],
                      block_op_failed: bfail_q[b],
                      rsv_hi: 2'h0,
                      prog_supply_error: bsup_q[b],
                      prog_supply_level: lvl_q,
                      rsv_lo: 1'b0};
  end

  // pins; enables are low while driving
  assign DQ_OUT                  = dq_q;
  assign DQ_OE_N_OUT[0]          = !(pd && sel && pins.we_n &&
                                     !pins.oe_n);
  assign DQ_OE_N_OUT[1]          = DQ_OE_N_OUT[0] || !pins.byte_n;
  assign READY_BUSY_N_OUT        = 1'b0;
  assign READY_BUSY_N_OE_N_OUT   = !(pd && mach_q == flash_pkg::M_BUSY);
  assign ARRAY_ADDR_OUT          = la_q;
  assign ARRAY_BANK_ODD_OUT      = la_q[1];
  assign READ_LATENCY_CONFIG_OUT = cfg_q;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  property p_latch;
    pd && sel && pins.we_n && !pins.addr_valid_n |=> la_q == $past(addr_s);
  endproperty
  a_latch: assert property (p_latch) else $error("address not latched");

  property p_inhibit;
    pins.addr_valid_n |=> $stable(la_q);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("address moved");

  property p_desel;
    !sel |-> DQ_OE_N_OUT == 2'b11;
  endproperty
  a_desel: assert property (p_desel) else $error("driven unselected");

  property p_pdown;
    !pd |-> DQ_OE_N_OUT == 2'b11 && READY_BUSY_N_OE_N_OUT;
  endproperty
  a_pdown: assert property (p_pdown) else $error("pins in power-down");

  property p_busy;
    go |=> !READY_BUSY_N_OE_N_OUT && !compat_st.machine_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");

  property p_supply;
    start && !supply_ok && mach_q == flash_pkg::M_IDLE |=>
      err_q.supply && gfail_q && mach_q == flash_pkg::M_IDLE;
  endproperty
  a_supply: assert property (p_supply) else $error("no supply abort");

  property p_auto;
    wr_stb && cst_q == flash_pkg::C_IDLE && cmd == `CMD_ERASE |=>
      rmode_q == flash_pkg::RD_COMPAT;
  endproperty
  a_auto: assert property (p_auto) else $error("no status switch");

  property p_clear;
    clr && pd && !set_supply && !set_fail |=>
      !err_q.supply && !gfail_q && bfail_q == '0 && bsup_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");

  property p_dflt;
    !pd |=> cfg_q == `LAT_DEFAULT && lock_q == '1;
  endproperty
  a_dflt: assert property (p_dflt) else $error("bad wake defaults");

  property p_prot;
    start && prot && supply_ok && mach_q == flash_pkg::M_IDLE |=>
      mach_q == flash_pkg::M_IDLE && gfail_q;
  endproperty
  a_prot: assert property (p_prot) else $error("locked block written");

  // data lane is registered, so its upper byte clears one edge later
  property p_byte;
    !pins.byte_n |-> DQ_OE_N_OUT[1] ##1 dq_q[15:8] == 8'h00;
  endproperty
  a_byte: assert property (p_byte) else $error("upper lane driven");

endmodule

`default_nettype wire

// *** hdl/flash_consts.svh ***
// constants for the flash command and status unit
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

// first and second cycle command codes, low data byte
`define CMD_READ_ARRAY  8'hFF
`define CMD_IDENT       8'h90
`define CMD_READ_COMPAT 8'h70
`define CMD_CLEAR       8'h50
`define CMD_PROG        8'h40
`define CMD_PROG_ALT    8'h10
`define CMD_ERASE       8'h20
`define CMD_SUSPEND     8'hB0
`define CMD_CONFIRM     8'hD0
`define CMD_READ_EXT    8'h71
`define CMD_LOCK        8'h77
`define CMD_UPLOAD      8'h97
`define CMD_CONFIG      8'h96

// configuration byte field and its default
`define LAT_MSB         5
`define LAT_LSB         3
`define LAT_DEFAULT     3'h4

// block layout of the byte address
`define NUM_BLOCKS      16
`define BLK_MSB         20
`define BLK_LSB         17

// extended status offsets inside a block, byte address
`define EXT_BLK_OFS     17'h00004
`define EXT_GLB_OFS     17'h00008

// internal operation time
`define OP_TIME_NS      2000
`define CLK_PERIOD_NS   50
`define OP_CYCLES ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** hdl/flash_pkg.sv ***
// types shared by the flash command and status unit
`default_nettype none

package flash_pkg;

  // synchronised control pins
  typedef struct packed {
    logic       pd_n;
    logic [1:0] cs_n;
    logic       oe_n;
    logic       we_n;
    logic       addr_valid_n;
    logic       byte_n;
    logic       wp_n;
    logic       supply_5v;
    logic       supply_12v;
  } bus_pins_t;

  typedef enum logic [3:0] {
    RD_ARRAY  = 4'h1,
    RD_IDENT  = 4'h2,
    RD_COMPAT = 4'h4,
    RD_EXT    = 4'h8
  } read_mode_t;

  typedef enum logic [5:0] {
    C_IDLE   = 6'h01,
    C_PROG   = 6'h02,
    C_ERASE  = 6'h04,
    C_LOCK   = 6'h08,
    C_UPLOAD = 6'h10,
    C_CONFIG = 6'h20
  } cmd_state_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h1,
    M_BUSY = 3'h2,
    M_SUSP = 3'h4
  } mach_state_t;

  typedef enum logic [3:0] {
    OP_PROG   = 4'h1,
    OP_ERASE  = 4'h2,
    OP_LOCK   = 4'h4,
    OP_UPLOAD = 4'h8
  } op_t;

  typedef struct packed {
    logic supply;
    logic prog;
    logic erase;
  } err_flags_t;

  typedef struct packed {
    logic       machine_ready;
    logic       erase_suspended;
    logic       erase_failed;
    logic       program_failed;
    logic       prog_supply_error;
    logic [2:0] rsv;
  } compat_t;

  typedef struct packed {
    logic       machine_ready;
    logic       op_suspended;
    logic       device_op_failed;
    logic [4:0] rsv;
  } global_t;

  typedef struct packed {
    logic       block_ready;
    logic       block_unlocked;
    logic       block_op_failed;
    logic [1:0] rsv_hi;
    logic       prog_supply_error;
    logic       prog_supply_level;
    logic       rsv_lo;
  } block_t;

endpackage

`default_nettype wire

// *** hdl/op_timer.sv ***
// countdown that stands in for the internal program and erase time
`default_nettype none

module op_timer #(
  parameter int unsigned CYCLES = 40
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // control
  input  wire logic clear_in,
  input  wire logic start_in,
  input  wire logic hold_in,
  // end of operation, one cycle
  output logic      done_out
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // hold freezes the count, so a suspended erase resumes where it stopped
  always_comb begin
    cnt_d = cnt_q;
    if (clear_in) begin
      cnt_d = '0;
    end else if (start_in) begin
      cnt_d = CW'(CYCLES);
    end else if (cnt_q != '0 && !hold_in) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done_out = (cnt_q == CW'(1)) && !hold_in && !clear_in;

endmodule

`default_nettype wire

// *** hdl/pin_sync.sv ***
// two-stage synchroniser for pin inputs
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  // raw and synchronised levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule

`default_nettype wire
